// *** logic/pcbs_pkg.sv ***
// Shared constants and types for the PWM current and back-EMF sampler.
// Assumes a single 20 MHz reference clock and counts expressed in clock cycles.
package pcbs_pkg;
    localparam int                CLK_PERIOD_NS = 50;     // Reference clock period
    localparam int                TMR_W         = 16;     // Width of every interval counter
    localparam int                BLANK_TIME_NS = 3000;   // Turn-on noise blanking time
    // Least time, so rounded up to whole cycles
    localparam logic [TMR_W-1:0]  BLANK_CYC     = TMR_W'((BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0]  TMR_CNT_RST   = 16'h0000; // Counter value after reset
    localparam logic              UPPER_RST     = 1'b0;     // Upper drivers off in reset
    localparam logic              LOWER_RST     = 1'b1;     // Lower driver held on from reset
    localparam logic              SAMPLE_RST    = 1'b0;     // No back-EMF sampling in reset
    localparam int                PREV_SHIFT    = 1;        // Extra mask is half the last period

    // Chopping sequence states
    typedef enum logic [1:0] {
        PCBS_ST_ON,     // Upper driver on, current rising
        PCBS_ST_SAMPLE, // Trip seen, floating phase checked
        PCBS_ST_OFF     // Constant OFF period
    } pcbs_state_t;

    // Mask length after a zero crossing: phase delay plus share of last period
    function automatic logic [TMR_W-1:0] pcbs_mask_len(input logic [TMR_W-1:0] dly,
                                                       input logic [TMR_W-1:0] prev);
        pcbs_mask_len = dly + (prev >> PREV_SHIFT);
    endfunction : pcbs_mask_len
endpackage : pcbs_pkg

// *** logic/pcbs_tmr_if.sv ***
// Carrier between the sampler and one of its interval counters.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface pcbs_tmr_if #(parameter int W = pcbs_pkg::TMR_W);
    logic         arm;   // High holds the counter loaded at its terminal count
    logic [W-1:0] tc;    // Terminal count in clock cycles
    logic [W-1:0] cnt;   // Present count
    logic         done;  // Interval expired, level until rearmed
    modport ctl (output arm, tc, input cnt, done);
    modport tmr (input arm, tc, output cnt, done);
endinterface : pcbs_tmr_if
`default_nettype wire

// *** logic/pcbs_timer.sv ***
// Programmable down counter used for OFF, blanking, limit and mask intervals.
// Assumes tc is stable while arm is high; counting starts when arm falls.
`timescale 1ns/1ps
`default_nettype none
module pcbs_timer (
    input  wire logic i_ref_clk,  // Reference clock
    input  wire logic i_rst_n,    // Asynchronous reset, active low
    pcbs_tmr_if.tmr   t           // Control and status
);
    import pcbs_pkg::*;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    // Load while armed, then count down and flag expiry
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            t.cnt  <= TMR_CNT_RST;
            t.done <= 1'b0;
        end else if (t.arm) begin // Held at terminal count
            t.cnt  <= t.tc;
            t.done <= 1'b0;
        end else if (t.cnt != '0) begin // Running
            t.cnt  <= t.cnt - 1'b1;
            t.done <= (t.cnt == 1);
        end else begin // Expired
            t.done <= 1'b1;
        end
    end

    count_step_a: assert property (!t.arm && t.cnt != '0 |=> t.cnt == $past(t.cnt) - 1'b1)
        else $error("counter did not step down by one");
endmodule : pcbs_timer
`default_nettype wire

// *** logic/pcbs_sampler.sv ***
// Constant-OFF-time current-mode PWM sequencer with back-EMF sample control.
// Assumes all inputs are synchronous to i_ref_clk; the comparator and
// zero-crossing detector are outside, as is the commutation counter.
//
// Functional notes
// - PWM trip: check back-EMF first, then OFF
// - PWM mode samples just before turn-off, and throughout ON after limit expiry
// - Ignore compare during blanking after turn-on
// - Blanking held through OFF, runs after
// - Compare high means current at or above control level
// - Linear: sample continuously after mask, until crossing
// - After crossing, mask for delay plus extra
// - Full duty in PWM stops back-EMF sampling
// - Limit timer cleared at OFF, times ON
// - Limit expiry restores continuous linear-style sampling
// - OFF period end turns upper drivers on
// - Lower driver stays on during OFF
// - Mode input selects PWM or linear control
`timescale 1ns/1ps
`default_nettype none
module pcbs_sampler #(
    parameter logic [pcbs_pkg::TMR_W-1:0] BLANK_CNT = pcbs_pkg::BLANK_CYC // Blanking length in cycles
) (
    input  wire logic                       i_ref_clk,     // 20 MHz reference clock
    input  wire logic                       i_rst_n,       // Asynchronous reset, active low
    input  wire logic                       i_pwm_mode,    // High selects PWM, low linear
    input  wire logic                       i_cur_cmp,     // Sensed current at or above control level
    input  wire logic                       i_bemf_zc,     // Floating phase has crossed zero
    input  wire logic [pcbs_pkg::TMR_W-1:0] i_off_cnt,     // Constant OFF period in cycles
    input  wire logic [pcbs_pkg::TMR_W-1:0] i_limit_cnt,   // Maximum ON time in cycles
    input  wire logic [pcbs_pkg::TMR_W-1:0] i_comm_dly,    // Commutation phase delay in cycles
    input  wire logic [pcbs_pkg::TMR_W-1:0] i_prev_period, // Previous commutation period in cycles
    output logic                            o_upper_on,    // Upper driver gate on
    output logic                            o_lower_on,    // Lower driver gate on
    output logic                            o_bemf_sample, // Floating phase sample enable
    output logic                            o_zc_pulse,    // Accepted zero crossing, one cycle
    output logic                            o_limit_hit    // ON time exceeded the limit
);
    import pcbs_pkg::*;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    pcbs_state_t st_r;      // Chopping state
    pcbs_state_t st_nxt;    // Next chopping state
    logic        cmp_ok;    // Compare result past blanking
    logic        sample_nxt; // Next sample enable

    pcbs_tmr_if off_if   (); // Constant OFF period
    pcbs_tmr_if blank_if (); // Turn-on blanking
    pcbs_tmr_if limit_if (); // PWM ON-time limit
    pcbs_tmr_if mask_if  (); // Post-crossing mask

    // Counter controls
    assign off_if.arm   = (st_r != PCBS_ST_OFF);   // Runs only during OFF
    assign off_if.tc    = i_off_cnt;
    assign blank_if.arm = (st_r == PCBS_ST_OFF);
    assign blank_if.tc  = BLANK_CNT;
    assign limit_if.arm = (st_r == PCBS_ST_OFF);
    assign limit_if.tc  = i_limit_cnt;
    assign mask_if.arm  = o_zc_pulse;
    assign mask_if.tc   = pcbs_mask_len(i_comm_dly, i_prev_period);

    pcbs_timer u_off_tmr   (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .t(off_if.tmr));
    pcbs_timer u_blank_tmr (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .t(blank_if.tmr));
    pcbs_timer u_limit_tmr (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .t(limit_if.tmr));
    pcbs_timer u_mask_tmr  (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .t(mask_if.tmr));

    // Compare only counts once blanking has run out
    assign cmp_ok = i_cur_cmp && blank_if.done;

    // Next chopping state
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            PCBS_ST_ON: begin // Linear mode never chops
                if (i_pwm_mode && cmp_ok) begin
                    st_nxt = PCBS_ST_SAMPLE;
                end
            end
            PCBS_ST_SAMPLE: begin // Sample taken, now turn off
                st_nxt = PCBS_ST_OFF;
            end
            PCBS_ST_OFF: begin
                if (off_if.done) begin
                    st_nxt = PCBS_ST_ON;
                end
            end
            default: begin
                st_nxt = PCBS_ST_OFF;
            end
        endcase
    end

    // State register; reset enters OFF so the first turn-on is blanked
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= PCBS_ST_OFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Driver gates
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_upper_on <= UPPER_RST;
            o_lower_on <= LOWER_RST;
        end else begin
            o_upper_on <= (st_nxt != PCBS_ST_OFF);
            o_lower_on <= 1'b1;
        end
    end

    // Sample enable: continuous in linear or after limit, else only at trip
    always_comb begin
        sample_nxt = 1'b0;
        if (mask_if.done && !o_zc_pulse) begin
            if (!i_pwm_mode) begin
                sample_nxt = 1'b1;
            end else if (st_r == PCBS_ST_ON && limit_if.done) begin
                sample_nxt = 1'b1;
            end else if (st_r == PCBS_ST_ON && cmp_ok) begin
                sample_nxt = 1'b1;
            end
        end
    end

    // Sample enable and accepted crossing
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_bemf_sample <= SAMPLE_RST;
            o_zc_pulse    <= 1'b0;
        end else begin
            o_bemf_sample <= sample_nxt;
            o_zc_pulse    <= o_bemf_sample && i_bemf_zc && mask_if.done && !o_zc_pulse;
        end
    end

    // Limit status
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_limit_hit <= 1'b0;
        end else begin
            o_limit_hit <= i_pwm_mode && limit_if.done;
        end
    end

    // Trip in PWM mode while upper driver is on
    sequence s_trip;
        i_pwm_mode && st_r == PCBS_ST_ON && cmp_ok;
    endsequence
    // Sample first, then upper off
    sequence s_sample_then_off;
        st_r == PCBS_ST_SAMPLE && o_upper_on ##1 st_r == PCBS_ST_OFF && !o_upper_on;
    endsequence

    trip_order_a: assert property (s_trip |=> s_sample_then_off)
        else $error("trip did not sample before turn-off");
    pwm_sample_a: assert property (i_pwm_mode && $past(i_pwm_mode) && o_bemf_sample && !o_limit_hit
                                   && $past(st_r) == PCBS_ST_ON |-> st_r == PCBS_ST_SAMPLE)
        else $error("PWM sample outside turn-off point");
    blank_gate_a: assert property (st_r == PCBS_ST_ON && !blank_if.done |=> st_r == PCBS_ST_ON)
        else $error("compare acted during blanking");
    blank_arm_a: assert property (st_r == PCBS_ST_OFF |=> !blank_if.done
                                  && blank_if.cnt == BLANK_CNT)
        else $error("blanking not held through OFF");
    cmp_trip_a: assert property (i_pwm_mode && st_r == PCBS_ST_ON && blank_if.done && i_cur_cmp
                                 |=> st_r == PCBS_ST_SAMPLE)
        else $error("compare did not trip");
    lin_sample_a: assert property (!i_pwm_mode && mask_if.done && !o_zc_pulse |=> o_bemf_sample)
        else $error("linear sampling not continuous");
    mask_load_a: assert property (o_zc_pulse |=> !mask_if.done
                                  && mask_if.cnt == pcbs_mask_len($past(i_comm_dly), $past(i_prev_period)))
        else $error("mask not reloaded after crossing");
    full_duty_a: assert property (i_pwm_mode && st_r == PCBS_ST_ON && !cmp_ok && !limit_if.done
                                  |=> !o_bemf_sample)
        else $error("sampled at full duty");
    limit_clear_a: assert property (st_r == PCBS_ST_OFF |=> !limit_if.done)
        else $error("limit timer not cleared in OFF");
    limit_sense_a: assert property (i_pwm_mode && st_r == PCBS_ST_ON && limit_if.done && mask_if.done
                                    && !o_zc_pulse |=> o_bemf_sample ##1 o_limit_hit || !i_pwm_mode)
        else $error("limit expiry did not sample");
    off_end_a: assert property (st_r == PCBS_ST_OFF && off_if.done |=> st_r == PCBS_ST_ON && o_upper_on)
        else $error("upper not restored after OFF");
    lower_hold_a: assert property (st_r == PCBS_ST_OFF |-> o_lower_on && !o_upper_on)
        else $error("lower driver dropped in OFF");
    lin_nochop_a: assert property (!i_pwm_mode && st_r == PCBS_ST_ON |=> st_r == PCBS_ST_ON)
        else $error("linear mode chopped");

    // Blanking loads on the turn-on edge and counts from the next
    sequence s_blank_run;
        blank_if.cnt == BLANK_CNT ##1 blank_if.cnt == BLANK_CNT - 1'b1;
    endsequence
    // Accepted crossing came from an enabled sample of a crossing
    sequence s_zc_cause;
        $past(o_bemf_sample) && $past(i_bemf_zc);
    endsequence

    // Blanking and limit timing around the end of OFF, and limit expiry flag
    blank_start_a: assert property ($fell(blank_if.arm) && BLANK_CNT != '0 |-> s_blank_run)
        else $error("blanking did not start at OFF end");
    limit_start_a: assert property ($fell(limit_if.arm) |-> limit_if.cnt == $past(i_limit_cnt))
        else $error("limit timer did not start at OFF end");
    limit_hit_a: assert property (i_pwm_mode && limit_if.done |=> o_limit_hit)
        else $error("limit expiry not flagged");
    // Crossing acceptance and mask
    zc_gate_a: assert property (o_zc_pulse |-> s_zc_cause)
        else $error("crossing accepted without a sample");
    zc_single_a: assert property (o_zc_pulse |=> !o_zc_pulse)
        else $error("crossing pulse longer than one cycle");
    mask_quiet_a: assert property (!mask_if.done |=> !o_bemf_sample)
        else $error("sampled while mask active");
    // Mode, driver gates and OFF loading
    lin_nolimit_a: assert property (!i_pwm_mode |=> !o_limit_hit)
        else $error("limit flagged in linear mode");
    upper_on_a: assert property (st_r != PCBS_ST_OFF |-> o_upper_on)
        else $error("upper driver off outside OFF");
    off_load_a: assert property ($rose(st_r == PCBS_ST_OFF) |-> off_if.cnt == $past(i_off_cnt) && !o_upper_on)
        else $error("OFF counter not loaded at turn-off");
endmodule : pcbs_sampler
`default_nettype wire

// *** tb/pcbs_motor.sv ***
// Behavioural motor and sense chain seen from the sampler's driver pins.
// Assumes the same clock as the sampler; the bench steers level and crossing.
`timescale 1ns/1ps
`default_nettype none
module pcbs_motor (
    input  wire logic       i_ref_clk,  // Reference clock
    input  wire logic       i_upper_on, // Upper driver gate
    input  wire logic [7:0] i_level,    // Commanded level, ff is never reached
    input  wire logic       i_zc_req,   // Bench asks for a crossing
    output logic            o_cur_cmp,  // Current or spike at or above level
    output logic            o_bemf_zc   // Floating phase crossed zero
);
    localparam logic [7:0] CUR_MAX = 8'h80; // Saturation, kept below the full-duty level
    logic [7:0] cur_r = 8'h00; // Winding current in steps
    logic [1:0] on_r  = 2'h0;  // Cycles since turn-on, saturating
    // Current ramps while driven and decays during the OFF period
    always_ff @(posedge i_ref_clk) begin
        if (i_upper_on && cur_r != CUR_MAX) cur_r <= cur_r + 8'h01;
        else if (!i_upper_on && cur_r != 8'h00) cur_r <= cur_r - 8'h01;
        on_r <= !i_upper_on ? 2'h0 : (on_r == 2'h3 ? on_r : on_r + 2'h1);
    end
    // A turn-on spike looks just like real current to the comparator
    assign o_cur_cmp = (i_level != 8'hff) && (cur_r >= i_level || (i_upper_on && on_r < 2'h3));
    assign o_bemf_zc = i_zc_req; // Crossing shown while the bench asks
endmodule : pcbs_motor
`default_nettype wire

// *** tb/pcbs_sampler_tb.sv ***
// Self-checking bench for the PWM current and back-EMF sampler.
// Assumes a motor model on the driver pins; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module pcbs_sampler_tb;
    import pcbs_pkg::*;
    typedef struct {int lo; int hi;} pcbs_len_t; // Allowed phase length
    localparam logic [TMR_W-1:0] BLK = 16'h0004; // Short blanking
    logic clk = 1'b0, rst_n = 1'b0, pwm = 1'b1, zc = 1'b0, up_d = 1'b0, zseen = 1'b0;
    logic up, lo, smp, zcp, lim, cmp, bzc;
    logic [7:0] lvl = 8'hff;
    logic [TMR_W-1:0] off_c = 16'h0008, lim_c = 16'hffff, dly = 16'h0000, prev = 16'h0000;
    int errors = 0, checks_done = 0, n = 0, k = 0, len = 0;
    bit watch = 1'b0;
    pcbs_len_t exp_q[$], e;
    always #25 clk = ~clk;
    pcbs_sampler #(.BLANK_CNT(BLK)) i_pcbs_sampler (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_pwm_mode(pwm), .i_cur_cmp(cmp), .i_bemf_zc(bzc), .i_off_cnt(off_c),
        .i_limit_cnt(lim_c), .i_comm_dly(dly), .i_prev_period(prev), .o_upper_on(up),
        .o_lower_on(lo), .o_bemf_sample(smp), .o_zc_pulse(zcp), .o_limit_hit(lim));
    pcbs_motor i_pcbs_motor (.i_ref_clk(clk), .i_upper_on(up), .i_level(lvl),
        .i_zc_req(zc), .o_cur_cmp(cmp), .o_bemf_zc(bzc));
    // Compare one bit
    task automatic chk_bit(string nm, logic ex, logic s);
        checks_done++;
        if (s !== ex) begin
            errors++;
            $display("MISMATCH %s expected %b seen %b", nm, ex, s);
        end
    endtask : chk_bit
    // Compare a cycle count against its allowed span
    task automatic chk_rng(string nm, int l, int h, int s);
        checks_done++;
        if (s < l || s > h) begin
            errors++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", nm, l, h, s);
        end
    endtask : chk_rng
    // Print counts and verdict, then stop
    task automatic finish_test();
        $display("Checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
    // Measures each driver phase and checks it against the oldest note
    always @(posedge clk) begin
        #1;
        len++;
        if (zcp === 1'b1) zseen = 1'b1;
        if (up !== up_d) begin
            if (watch && exp_q.size() > 0) begin
                e = exp_q.pop_front();
                chk_rng("phase_len", e.lo, e.hi, len);
                chk_bit("lower_on", 1'b1, lo);
            end
            len = 0;
        end
        up_d = up;
    end
    // Cuts a hang short
    initial begin
        #3000000;
        errors++;
        finish_test();
    end
    // Main sequence
    initial begin
        n = $urandom(99125);
        repeat (6) @(negedge clk);
        chk_bit("upper_rst", 1'b0, up);
        chk_bit("lower_rst", 1'b1, lo);
        chk_bit("sample_rst", 1'b0, smp);
        rst_n = 1'b1;
        off_c = 16'h0005 + 16'($urandom_range(7));
        lvl = 8'h00;
        zc = 1'b1;
        // Chop with current always over the level: blanked ON, fixed OFF
        @(posedge up);
        @(negedge clk);
        for (k = 0; k < 3; k++) begin
            exp_q.push_back('{int'(BLK) + 1, int'(BLK) + 3});
            exp_q.push_back('{int'(off_c) + 1, int'(off_c) + 2});
        end
        watch = 1'b1;
        wait (exp_q.size() == 0);
        watch = 1'b0;
        chk_bit("zc_at_trip", 1'b1, zseen);
        // Only turn-on spikes over the level: full duty, no sampling
        @(negedge clk);
        lvl = 8'hc8;
        zc = 1'b0;
        // The ON phase that has just begun is watched; it must never end
        n = 0;
        repeat (150) @(negedge clk) n += (smp === 1'b1) + 2 * (up !== 1'b1);
        chk_rng("full_duty", 0, 0, n);
        // Limit timer reloads on the next OFF and then times the ON period
        lim_c = 16'h001e;
        lvl = 8'h00;
        @(negedge up);
        @(negedge clk);
        chk_bit("limit_clr", 1'b0, lim);
        lvl = 8'hc8;
        @(posedge up);
        n = 0;
        while (lim !== 1'b1 && n < 60) @(negedge clk) n++;
        chk_rng("limit_time", 29, 34, n);
        n = 0;
        repeat (10) @(negedge clk) n += (smp === 1'b1);
        chk_rng("limit_sample", 10, 10, n);
        // A trip now clears the expired limit once OFF has begun
        lvl = 8'h00;
        @(negedge up);
        repeat (3) @(negedge clk);
        chk_bit("limit_reclr", 1'b0, lim);
        // Linear mode: continuous sampling, then mask after a crossing
        pwm = 1'b0;
        lvl = 8'hff;
        repeat (20) @(negedge clk);
        n = 0;
        repeat (10) @(negedge clk) n += (smp === 1'b1);
        chk_rng("linear_sample", 10, 10, n);
        dly = 16'h0014;
        prev = 16'h0014;
        zc = 1'b1;
        n = 0;
        while (zcp !== 1'b1 && n < 5) @(negedge clk) n++;
        chk_bit("linear_zc", 1'b1, zcp);
        zc = 1'b0;
        // Sampling stops once the mask is rearmed
        @(negedge clk);
        chk_bit("mask_on", 1'b0, smp);
        n = 0;
        while (smp !== 1'b1 && n < 60) @(negedge clk) n++;
        chk_rng("mask_len", 29, 34, n);
        finish_test();
    end
endmodule : pcbs_sampler_tb
`default_nettype wire
